//--- design/eds_pkg.sv
// Constants, register map and field layout of the syndrome engine
// How it works
// - Two data words form one 64-bit input
// - Low word bits 31:0, high word 63:32
// - Code input holds 20 bits, rest reserved
// - Shared inputs, each result own register
// - Encode 7-bit code from low word
// - Check low word against code bits 6:0
// - Return data and code, corrected if single
// - Code 6:0, single flag 8, multi 9
// - Encode 8-bit code from all 64 bits
// - Check 64 bits against code bits 7:0
// - Corrected 64-bit data in two registers
// - Corrected 8-bit code plus both flags
// - Four 5-bit byte codes, encode and check
// - Byte codes packed five bits per byte
// - Byte checker: code, single and multi flags
// - No register update without clock enable, except synchronous reset
// - Identification register at offset 0xFFC
package eds_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [11:0] OFF_DATA_LOW = 12'h000;
    localparam logic [11:0] OFF_DATA_HIGH = 12'h004;
    localparam logic [11:0] OFF_CODE_IN = 12'h008;
    localparam logic [11:0] OFF_C7_ENC = 12'h00C;
    localparam logic [11:0] OFF_C7_DATA = 12'h010;
    localparam logic [11:0] OFF_C7_STAT = 12'h014;
    localparam logic [11:0] OFF_C8_ENC = 12'h018;
    localparam logic [11:0] OFF_C8_DATA_LOW = 12'h01C;
    localparam logic [11:0] OFF_C8_DATA_HIGH = 12'h020;
    localparam logic [11:0] OFF_C8_STAT = 12'h024;
    localparam logic [11:0] OFF_BC_ENC = 12'h028;
    localparam logic [11:0] OFF_BC_DATA = 12'h02C;
    localparam logic [11:0] OFF_BC_STAT = 12'h030;
    localparam logic [11:0] OFF_IDENT = 12'hFFC;
    // Reset values of the writable inputs
    localparam logic [31:0] RST_DATA = 32'h0000_0000;
    localparam logic [19:0] RST_CODE = 20'h0_0000;
    // Field layout
    localparam int CODE_IN_W = 20;
    localparam int C7_DATA_N = 32;
    localparam int C7_HAM_R = 6;
    localparam int C8_DATA_N = 64;
    localparam int C8_HAM_R = 7;
    localparam int BC_DATA_N = 8;
    localparam int BC_HAM_R = 4;
    localparam int BC_LANES = 4;
    localparam int BC_CODE_W = 5;
    localparam int STAT_SINGLE_BIT = 8;
    localparam int STAT_MULTI_BIT = 9;
    localparam int BC_SINGLE_LSB = 24;
    localparam int BC_MULTI_LSB = 28;
    // Identification value, arbitrary
    localparam logic [31:0] IDENT_VALUE = 32'h0A5E_0001;
endpackage

//--- design/eds_syndrome_engine.sv
// Syndrome engine: input registers, three code families, Avalon-MM slave
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
module eds_syndrome_engine (
    // Clock, reset and gate
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEnable,
    // Avalon-MM slave
    input wire logic [11:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest
);

    // Extended Hamming encoder: r position checks plus overall parity in bit r
    // Data sits at non-power-of-two positions; positions past n are skipped
    // Loops run to 127 so one function serves all three code widths
    function automatic logic [7:0] hamEnc(input logic [63:0] d, input int n, input int r);
        logic [7:0] c;
        int k;
        int p;
        int i;
        c = 8'h00;
        k = 0;
        for (p = 1; p < 128; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (k < n) begin
                    for (i = 0; i < 7; i++) begin
                        if (i < r && ((p >> i) & 1) == 1) begin
                            c[i] = c[i] ^ d[k];
                        end
                    end
                    c[r] = c[r] ^ d[k];
                end
                k = k + 1;
            end
        end
        for (i = 0; i < 7; i++) begin
            if (i < r) begin
                c[r] = c[r] ^ c[i];
            end
        end
        return c;
    endfunction

    // Checker: returns {multi, single, corrected code, corrected data}
    function automatic logic [73:0] hamCheck(input logic [63:0] d, input logic [7:0] cin,
                                             input int n, input int r);
        logic [7:0] calc;
        logic [7:0] code;
        logic [63:0] dat;
        logic [6:0] syn;
        logic par;
        logic hit;
        int k;
        int p;
        int i;
        calc = hamEnc(d, n, r);
        code = cin;
        dat = d;
        syn = 7'h00;
        hit = 1'b0;
        k = 0;
        for (i = 0; i < 7; i++) begin
            if (i < r) begin
                syn[i] = calc[i] ^ cin[i];
            end
        end
        // Received overall parity error
        par = calc[r] ^ cin[r] ^ (^syn);
        if (par) begin
            if (syn == 7'h00) begin
                code[r] = ~code[r];
                hit = 1'b1;
            end
            for (i = 0; i < 7; i++) begin
                if (i < r && int'(syn) == (1 << i)) begin
                    code[i] = ~code[i];
                    hit = 1'b1;
                end
            end
            for (p = 1; p < 128; p++) begin
                if ((p & (p - 1)) != 0) begin
                    if (k < n && int'(syn) == p) begin
                        dat[k] = ~dat[k];
                        hit = 1'b1;
                    end
                    k = k + 1;
                end
            end
        end
        // Odd error with an unused syndrome counts as multiple
        return {(syn != 7'h00 && !par) || (par && !hit), par && hit, code, dat};
    endfunction

    // Shared input registers
    logic [31:0] dataLow;
    logic [31:0] dataHigh;
    logic [19:0] codeIn;
    logic [63:0] dataAll;
    // Transfer strobes
    logic busReq;
    logic wrTake;
    // Family results
    logic [6:0] enc7;
    logic [31:0] chk7Data;
    logic [6:0] chk7Code;
    logic chk7Single;
    logic chk7Multi;
    logic [7:0] enc8;
    logic [63:0] chk8Data;
    logic [7:0] chk8Code;
    logic chk8Single;
    logic chk8Multi;
    logic [19:0] encBc;
    logic [31:0] chkBcData;
    logic [19:0] chkBcCode;
    logic [3:0] chkBcSingle;
    logic [3:0] chkBcMulti;
    // Re-encoded corrected words, checking only
    logic [7:0] fix7;
    logic [7:0] fix8;
    logic [31:0] next_readdata;

    // Combined data word
    assign dataAll = {dataHigh, dataLow};
    assign busReq = read || write;
    // Write lands only at the acknowledge edge and only with the clock running
    assign wrTake = write && !waitrequest && clkEnable;

    // Trade-off: results are combinational, so they follow the inputs at once
    // 32-bit family
    always_comb begin
        logic [7:0] e;
        logic [73:0] res;
        e = hamEnc({32'h0000_0000, dataLow}, eds_pkg::C7_DATA_N, eds_pkg::C7_HAM_R);
        res = hamCheck({32'h0000_0000, dataLow}, {1'b0, codeIn[6:0]},
                       eds_pkg::C7_DATA_N, eds_pkg::C7_HAM_R);
        enc7 = e[6:0];
        chk7Data = res[31:0];
        chk7Code = res[70:64];
        chk7Single = res[72];
        chk7Multi = res[73];
    end

    // 64-bit family
    always_comb begin
        logic [73:0] res;
        res = hamCheck(dataAll, codeIn[7:0], eds_pkg::C8_DATA_N, eds_pkg::C8_HAM_R);
        enc8 = hamEnc(dataAll, eds_pkg::C8_DATA_N, eds_pkg::C8_HAM_R);
        chk8Data = res[63:0];
        chk8Code = res[71:64];
        chk8Single = res[72];
        chk8Multi = res[73];
    end

    // A fix must land on a valid codeword, so re-encode the corrected data
    assign fix7 = hamEnc({32'h0000_0000, chk7Data}, eds_pkg::C7_DATA_N, eds_pkg::C7_HAM_R);
    assign fix8 = hamEnc(chk8Data, eds_pkg::C8_DATA_N, eds_pkg::C8_HAM_R);

    // Byte family: one independent code per byte lane
    for (genvar g = 0; g < eds_pkg::BC_LANES; g++) begin : gen_lane
        logic [7:0] e;
        logic [73:0] res;
        assign e = hamEnc({56'h0, dataLow[8*g +: 8]}, eds_pkg::BC_DATA_N, eds_pkg::BC_HAM_R);
        assign res = hamCheck({56'h0, dataLow[8*g +: 8]},
                              {3'h0, codeIn[eds_pkg::BC_CODE_W*g +: eds_pkg::BC_CODE_W]},
                              eds_pkg::BC_DATA_N, eds_pkg::BC_HAM_R);
        assign encBc[eds_pkg::BC_CODE_W*g +: eds_pkg::BC_CODE_W] = e[4:0];
        assign chkBcData[8*g +: 8] = res[7:0];
        assign chkBcCode[eds_pkg::BC_CODE_W*g +: eds_pkg::BC_CODE_W] = res[68:64];
        assign chkBcSingle[g] = res[72];
        assign chkBcMulti[g] = res[73];
        logic [7:0] fix;
        assign fix = hamEnc({56'h0, res[7:0]}, eds_pkg::BC_DATA_N, eds_pkg::BC_HAM_R);
        // Corrected lane must re-encode to its own corrected code
        AST_BC_FIX: assert property (@(posedge ref_clk) disable iff (!rst_n)
            !res[73] |-> fix[4:0] == res[68:64])
            else $error("byte lane correction inconsistent");
    end

    // Input word registers, byte lanes honoured
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dataLow <= eds_pkg::RST_DATA;
            dataHigh <= eds_pkg::RST_DATA;
        end else if (wrTake) begin
            for (int b = 0; b < 4; b++) begin
                if (byteenable[b] && address == eds_pkg::OFF_DATA_LOW) begin
                    dataLow[8*b +: 8] <= writedata[8*b +: 8];
                end
                if (byteenable[b] && address == eds_pkg::OFF_DATA_HIGH) begin
                    dataHigh[8*b +: 8] <= writedata[8*b +: 8];
                end
            end
        end
    end

    // Code input: only 20 bits exist, upper lanes drop
    // Lane 3 and bits 23:20 of lane 2 have no storage, so bits 31:20 can never read back non-zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            codeIn <= eds_pkg::RST_CODE;
        end else if (wrTake && address == eds_pkg::OFF_CODE_IN) begin
            if (byteenable[0]) begin
                codeIn[7:0] <= writedata[7:0];
            end
            if (byteenable[1]) begin
                codeIn[15:8] <= writedata[15:8];
            end
            if (byteenable[2]) begin
                codeIn[19:16] <= writedata[19:16];
            end
        end
    end

    // Read decode; result writes and reserved space fall through untouched
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            eds_pkg::OFF_DATA_LOW: next_readdata = dataLow;
            eds_pkg::OFF_DATA_HIGH: next_readdata = dataHigh;
            eds_pkg::OFF_CODE_IN: next_readdata = {12'h000, codeIn};
            eds_pkg::OFF_C7_ENC: next_readdata = {25'h0, enc7};
            eds_pkg::OFF_C7_DATA: next_readdata = chk7Data;
            eds_pkg::OFF_C7_STAT:
                next_readdata = {22'h0, chk7Multi, chk7Single, 1'b0, chk7Code};
            eds_pkg::OFF_C8_ENC: next_readdata = {24'h0, enc8};
            eds_pkg::OFF_C8_DATA_LOW: next_readdata = chk8Data[31:0];
            eds_pkg::OFF_C8_DATA_HIGH: next_readdata = chk8Data[63:32];
            eds_pkg::OFF_C8_STAT:
                next_readdata = {22'h0, chk8Multi, chk8Single, chk8Code};
            eds_pkg::OFF_BC_ENC: next_readdata = {12'h000, encBc};
            eds_pkg::OFF_BC_DATA: next_readdata = chkBcData;
            eds_pkg::OFF_BC_STAT:
                next_readdata = {chkBcMulti, chkBcSingle, 4'h0, chkBcCode};
            eds_pkg::OFF_IDENT: next_readdata = eds_pkg::IDENT_VALUE;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // Waitrequest: drops for one cycle, one cycle after a request appears
    // Limitation: gating in the acknowledge cycle freezes it low until enabled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else if (clkEnable) begin
            waitrequest <= !(busReq && waitrequest);
        end
    end

    // Read data captured at the edge where waitrequest drops; frozen while gated
    // Capturing early lets the acknowledge edge see settled data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (clkEnable && read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Bus handshake and gating
    AST_ACK_NEXT: assert property (busReq && waitrequest && clkEnable |=> !waitrequest)
        else $error("request not acknowledged one cycle later");
    AST_ACK_ONE: assert property (!waitrequest && clkEnable |=> waitrequest)
        else $error("acknowledge held longer than one cycle");
    AST_READ_HOLD: assert property (!waitrequest && read |=> $stable(readdata))
        else $error("read data moved after acknowledge");
    AST_GATED_FREEZE: assert property (!clkEnable
        |=> $stable(dataLow) && $stable(dataHigh) && $stable(codeIn) && $stable(readdata))
        else $error("register changed with clock enable low");

    // Input registers: full writes land, other space leaves them alone
    AST_WRITE_LOW: assert property (write && !waitrequest && clkEnable
        && byteenable == 4'hF && address == eds_pkg::OFF_DATA_LOW
        |=> dataLow == $past(writedata))
        else $error("low data word write lost");
    AST_WRITE_HIGH: assert property (write && !waitrequest && clkEnable
        && byteenable == 4'hF && address == eds_pkg::OFF_DATA_HIGH
        |=> dataHigh == $past(writedata))
        else $error("high data word write lost");
    AST_CODE_WRITE: assert property (write && !waitrequest && clkEnable
        && byteenable == 4'hF && address == eds_pkg::OFF_CODE_IN
        |=> codeIn == $past(writedata[19:0]))
        else $error("code input write lost");
    AST_RO_WRITE: assert property (write && !waitrequest && clkEnable
        && address > eds_pkg::OFF_CODE_IN
        |=> $stable(dataLow) && $stable(dataHigh) && $stable(codeIn))
        else $error("write outside the input registers changed state");

    // Read layouts at the acknowledge edge
    AST_CODE_RSV: assert property (!waitrequest && read
        && address == eds_pkg::OFF_CODE_IN |-> readdata[31:20] == 12'h000)
        else $error("code input reserved bits not zero");
    AST_ENC7_ZERO: assert property (!waitrequest && read
        && address == eds_pkg::OFF_C7_ENC |-> readdata[31:7] == 25'h0
        && readdata[6:0] == $past(enc7))
        else $error("7-bit encode read wrong");
    AST_C7_STAT_PAD: assert property (!waitrequest && read
        && address == eds_pkg::OFF_C7_STAT |-> readdata[31:10] == 22'h0 && !readdata[7])
        else $error("7-bit status unused bits not zero");
    AST_ENC8_ZERO: assert property (!waitrequest && read
        && address == eds_pkg::OFF_C8_ENC |-> readdata[31:8] == 24'h0
        && readdata[7:0] == $past(enc8))
        else $error("8-bit encode read wrong");
    AST_C8_STAT_PAD: assert property (!waitrequest && read
        && address == eds_pkg::OFF_C8_STAT |-> readdata[31:10] == 22'h0)
        else $error("8-bit status unused bits not zero");
    AST_BC_ENC_ZERO: assert property (!waitrequest && read
        && address == eds_pkg::OFF_BC_ENC |-> readdata[31:20] == 12'h000
        && readdata[19:0] == $past(encBc))
        else $error("byte encode read wrong");
    AST_BC_STAT_GAP: assert property (!waitrequest && read
        && address == eds_pkg::OFF_BC_STAT |-> readdata[23:20] == 4'h0)
        else $error("byte status gap bits not zero");
    AST_IDENT: assert property (!waitrequest && read
        && address == eds_pkg::OFF_IDENT |-> readdata == eds_pkg::IDENT_VALUE)
        else $error("identification read wrong");
    AST_RSV_ZERO: assert property (!waitrequest && read
        && address == 12'h100 |-> readdata == 32'h0000_0000)
        else $error("reserved read not zero");

    // Checker results: clean words pass, corrections stay consistent
    AST_C7_CLEAN: assert property (codeIn[6:0] == enc7
        |-> !chk7Single && !chk7Multi && chk7Data == dataLow && chk7Code == enc7)
        else $error("clean word flagged or altered");
    AST_C7_FLAGS: assert property (!(chk7Single && chk7Multi)
        && !(chk8Single && chk8Multi))
        else $error("single and multi flags both set");
    AST_C7_FIX: assert property (!chk7Multi |-> fix7[6:0] == chk7Code)
        else $error("7-bit correction inconsistent");
    AST_C8_CLEAN: assert property (codeIn[7:0] == enc8
        |-> !chk8Single && !chk8Multi && chk8Data == dataAll)
        else $error("clean 64-bit word flagged or altered");
    AST_C8_FIX: assert property (!chk8Multi |-> fix8 == chk8Code)
        else $error("64-bit correction inconsistent");
    AST_BC_CLEAN: assert property (codeIn == encBc
        |-> chkBcSingle == 4'h0 && chkBcMulti == 4'h0 && chkBcData == dataLow)
        else $error("clean byte word flagged");

    COV_WRITE: cover property (wrTake);
    COV_READ_ENC8: cover property (!waitrequest && read && address == eds_pkg::OFF_C8_ENC);
    COV_SINGLE7: cover property (chk7Single);
    COV_MULTI_BYTE: cover property (chkBcMulti != 4'h0);
    COV_GATED_REQ: cover property (busReq && !clkEnable);

endmodule

//--- dv/eds_tb.sv
// Self-checking bench for the syndrome engine against a reference code model
`timescale 1ns/10ps
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEnable = 1'b1;
    logic [11:0] address = 12'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    int n_errors = 0;
    int checks_done = 0;
    logic [31:0] rngState = 32'h0000_7429;

    eds_syndrome_engine dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clkEnable(clkEnable),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest)
    );

    // 125 MHz clock
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // Xorshift source, fixed seed for repeatable runs
    function automatic logic [31:0] rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    // Extended Hamming encoder: data at non-power-of-two positions, top bit overall parity
    function automatic logic [7:0] ham_enc(input logic [63:0] d, input int n, input int r);
        logic [7:0] c;
        logic par;
        int p, k, i;
        c = 8'h00;
        par = 1'b0;
        p = 2;
        for (k = 0; k < n; k++) begin
            p++;
            while ((p & (p - 1)) == 0) p++;
            par ^= d[k];
            for (i = 0; i < r; i++) if (p[i]) c[i] ^= d[k];
        end
        c[r] = par ^ (^c);
        return c;
    endfunction

    // Decoder model: returns {multi, single, code, data}
    function automatic logic [73:0] ham_chk(input logic [63:0] d, input logic [7:0] c,
                                            input int n, input int r);
        logic [7:0] e, s;
        logic pe, oneErr, manyErr;
        int p, k, i;
        e = ham_enc(d, n, r);
        s = 8'h00;
        for (i = 0; i < r; i++) s[i] = e[i] ^ c[i];
        pe = e[r] ^ c[r] ^ (^s);
        oneErr = 1'b0;
        manyErr = 1'b0;
        if (pe && s == 8'h00) begin
            c[r] = ~c[r];
            oneErr = 1'b1;
        end else if (pe) begin
            for (i = 0; i < r; i++) begin
                if (s == (8'h01 << i)) begin
                    c[i] = ~c[i];
                    oneErr = 1'b1;
                end
            end
            p = 2;
            for (k = 0; k < n; k++) begin
                p++;
                while ((p & (p - 1)) == 0) p++;
                if (p == int'(s)) begin
                    d[k] = ~d[k];
                    oneErr = 1'b1;
                end
            end
            manyErr = ~oneErr;
        end else begin
            manyErr = (s != 8'h00);
        end
        return {manyErr, oneErr, c, d};
    endfunction

    // Four byte-lane codes packed five bits apart
    function automatic logic [19:0] bc_enc(input logic [31:0] d);
        logic [19:0] v;
        logic [7:0] t;
        int g;
        for (g = 0; g < 4; g++) begin
            t = ham_enc({56'h0, d[8*g+:8]}, 8, 4);
            v[5*g+:5] = t[4:0];
        end
        return v;
    endfunction

    task automatic stop_test();
        $display("errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] wd,
                        input logic [3:0] be, output logic [31:0] rd);
        int k;
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= wd;
        byteenable <= be;
        for (k = 0; k < 60; k++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        if (k == 60) begin n_errors++; stop_test(); end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_cmp(input logic [11:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h0000_0000, 4'hF, v);
        cmp(nm, exp, v);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] be);
        logic [31:0] unused;
        xfer(a, 1'b1, v, be, unused);
    endtask

    // Load shared inputs, then compare every result register with the model
    task automatic check_all(input logic [63:0] d, input logic [19:0] c);
        logic [73:0] r7, r8, rb;
        logic [31:0] cbd, cbs;
        logic [7:0] t;
        int g;
        wr(eds_pkg::OFF_DATA_LOW, d[31:0], 4'hF);
        wr(eds_pkg::OFF_DATA_HIGH, d[63:32], 4'hF);
        wr(eds_pkg::OFF_CODE_IN, {12'h000, c}, 4'hF);
        r7 = ham_chk({32'h0, d[31:0]}, {1'b0, c[6:0]}, 32, 6);
        r8 = ham_chk(d, c[7:0], 64, 7);
        cbd = 32'h0000_0000;
        cbs = 32'h0000_0000;
        for (g = 0; g < 4; g++) begin
            rb = ham_chk({56'h0, d[8*g+:8]}, {3'h0, c[5*g+:5]}, 8, 4);
            cbd[8*g+:8] = rb[7:0];
            cbs[5*g+:5] = rb[68:64];
            cbs[24+g] = rb[72];
            cbs[28+g] = rb[73];
        end
        t = ham_enc({32'h0, d[31:0]}, 32, 6);
        rd_cmp(eds_pkg::OFF_C7_ENC, {25'h0, t[6:0]}, "c7enc");
        rd_cmp(eds_pkg::OFF_C7_DATA, r7[31:0], "c7data");
        rd_cmp(eds_pkg::OFF_C7_STAT, {22'h0, r7[73:72], 1'b0, r7[70:64]}, "c7stat");
        t = ham_enc(d, 64, 7);
        rd_cmp(eds_pkg::OFF_C8_ENC, {24'h0, t}, "c8enc");
        rd_cmp(eds_pkg::OFF_C8_DATA_LOW, r8[31:0], "c8low");
        rd_cmp(eds_pkg::OFF_C8_DATA_HIGH, r8[63:32], "c8high");
        rd_cmp(eds_pkg::OFF_C8_STAT, {22'h0, r8[73:64]}, "c8stat");
        rd_cmp(eds_pkg::OFF_BC_ENC, {12'h0, bc_enc(d[31:0])}, "bcenc");
        rd_cmp(eds_pkg::OFF_BC_DATA, cbd, "bcdata");
        rd_cmp(eds_pkg::OFF_BC_STAT, cbs, "bcstat");
    endtask

    initial begin
        logic [63:0] d;
        logic [19:0] c;
        logic [7:0] t;
        int b, f, e, i, cw;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd_cmp(eds_pkg::OFF_DATA_LOW, 32'h0000_0000, "rstlow");
        rd_cmp(eds_pkg::OFF_DATA_HIGH, 32'h0000_0000, "rsthigh");
        rd_cmp(eds_pkg::OFF_CODE_IN, 32'h0000_0000, "rstcode");
        wr(eds_pkg::OFF_CODE_IN, 32'hFFFF_FFFF, 4'hF);
        rd_cmp(eds_pkg::OFF_CODE_IN, 32'h000F_FFFF, "codein");
        wr(eds_pkg::OFF_DATA_HIGH, 32'hFFFF_FFFF, 4'hF);
        wr(eds_pkg::OFF_DATA_HIGH, 32'h1234_5678, 4'h5);
        rd_cmp(eds_pkg::OFF_DATA_HIGH, 32'hFF34_FF78, "lanes");
        // Writes to read-only and unmapped space must leave everything alone
        wr(eds_pkg::OFF_IDENT, 32'h0000_0000, 4'hF);
        wr(eds_pkg::OFF_C7_ENC, 32'hFFFF_FFFF, 4'hF);
        wr(12'h100, 32'hFFFF_FFFF, 4'hF);
        rd_cmp(eds_pkg::OFF_IDENT, eds_pkg::IDENT_VALUE, "ident");
        rd_cmp(12'h100, 32'h0000_0000, "rsv100");
        rd_cmp(12'hFF8, 32'h0000_0000, "rsvff8");
        rd_cmp(eds_pkg::OFF_DATA_HIGH, 32'hFF34_FF78, "keep");
        // Gate off: the write must stall until the enable returns
        clkEnable <= 1'b0;
        @(posedge ref_clk);
        fork
            wr(eds_pkg::OFF_DATA_LOW, 32'hCAFE_0123, 4'hF);
            begin
                repeat (10) begin
                    @(posedge ref_clk);
                    cmp("stall", 32'h0000_0001, {31'h0, waitrequest});
                end
                clkEnable <= 1'b1;
            end
        join
        rd_cmp(eds_pkg::OFF_DATA_LOW, 32'hCAFE_0123, "gated");
        // Per family: clean, data flip, code flip, double data flip
        for (i = 0; i < 24; i++) begin
            f = i % 3;
            e = (i / 3) % 4;
            d = {rnd(), rnd()};
            case (f)
                0: begin t = ham_enc({32'h0, d[31:0]}, 32, 6); c = {13'h0, t[6:0]}; cw = 7; end
                1: begin t = ham_enc(d, 64, 7); c = {12'h0, t}; cw = 8; end
                default: begin c = bc_enc(d[31:0]); cw = 20; end
            endcase
            b = int'(rnd() % ((f == 1) ? 64 : 32));
            if (e == 1 || e == 3) d[b] = ~d[b];
            if (e == 3) d[b ^ 1] = ~d[b ^ 1];
            if (e == 2) c[int'(rnd() % cw)] ^= 1'b1;
            check_all(d, c);
        end
        stop_test();
    end
endmodule
